// *** logic/dram_cfg_pkg.sv ***
package dram_cfg_pkg;

    // Register byte offsets, 16-bit data port
    localparam logic [11:0] OFF_TERM_LO = 12'h29C;
    localparam logic [11:0] OFF_TERM_HI = 12'h29E;
    localparam logic [11:0] OFF_BND1 = 12'h602;
    localparam logic [11:0] OFF_BND2 = 12'h604;
    localparam logic [11:0] OFF_BND3 = 12'h606;
    localparam logic [11:0] OFF_ATTR_LO = 12'h608;
    localparam logic [11:0] OFF_ATTR_HI = 12'h60A;
    localparam logic [11:0] OFF_PCHG = 12'h650;

    // Termination control fields
    localparam int TERM_W = 4;
    localparam int CTRL_TERM_LSB = 0;
    localparam int WR_TERM_LSB = 4;
    localparam int RD_TERM_LSB = 8;
    localparam logic [11:0] TERM_RESET = 12'h000;

    // Rank boundary and attribute fields
    localparam int BND_W = 10;
    localparam logic [9:0] BND_RESET = 10'h000;
    localparam int ATTR_W = 8;
    localparam logic [7:0] ATTR_RESET = 8'h00;

    // Precharge spacing fields
    localparam int PP_LSB = 0;
    localparam int PP_W = 2;
    localparam int RP_LSB = 2;
    localparam int RP_W = 4;
    localparam int WP_LSB = 6;
    localparam int WP_W = 5;
    localparam logic [10:0] PCHG_RESET = 11'h000;

    localparam int RANKS = 4;
    localparam int BANKS = 8;

    typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_PCHG, CMD_OTHER} cmd_kind_t;

    typedef struct packed {
        logic valid;
        cmd_kind_t kind;
        logic channel;
        logic [1:0] rank;
        logic [2:0] bank;
    } cmd_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } reg_req_t;

endpackage

// *** logic/spacing_timer.sv ***
`timescale 1ns/1ps
module spacing_timer #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic [W-1:0] next_count
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] dec;

    // A newer command never shortens a window already running
    always_comb
    begin
        dec = (cnt_q == '0) ? '0 : W'(cnt_q - W'(1));
        next_count = (load && (value > dec)) ? value : dec;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= '0;
        else
            cnt_q <= next_count;
    end
endmodule

// *** logic/dram_channel_odt_rank_precharge_cfg.sv ***
`timescale 1ns/1ps
// Function
// - DRAM termination held read duration after channel 0 reads
// - DRAM termination held write duration after channel 0 writes
// - Controller termination held its duration on channel 0 reads
// - Boundary registers: 10 writable bits, upper zero
// - Stolen-memory lock freezes boundaries and attributes
// - One 8-bit attribute per rank, paired
// - Channel 1 write to precharge spacing per rank-bank
// - Channel 1 read to precharge spacing per rank-bank
// - Channel 1 precharge to precharge spacing per rank
module dram_channel_odt_rank_precharge_cfg (
    input wire logic clk,
    input wire logic rstn,
    input wire dram_cfg_pkg::reg_req_t reg_req,
    output logic [15:0] reg_rdata_q,
    output logic reg_rvalid_q,
    input wire dram_cfg_pkg::cmd_t cmd,
    input wire logic stolen_lock,
    output logic dram_odt_q,
    output logic ctrl_odt_q,
    output logic [31:0] pchg_block_q
);
    logic [11:0] term_q;
    logic [9:0] bnd_q [3];
    logic [7:0] attr_q [4];
    logic [10:0] pchg_q;

    logic [3:0] read_term_duration;
    logic [3:0] write_term_duration;
    logic [3:0] ctrl_term_duration;
    logic [4:0] ch1_write_to_pchg_gap;
    logic [3:0] ch1_read_to_pchg_gap;
    logic [1:0] ch1_pchg_to_pchg_gap;

    logic wr_lo;
    logic wr_hi;
    logic ch0_rd;
    logic ch0_wr;
    logic ch1_rd;
    logic ch1_wr;
    logic ch1_pc;
    logic [3:0] rd_odt_nx;
    logic [3:0] wr_odt_nx;
    logic [3:0] ctl_odt_nx;
    logic [31:0] block_d;
    logic [31:0] wp_hold;
    logic [31:0] rp_hold;
    logic [3:0] pp_hold;
    logic [15:0] rdata_d;

    assign read_term_duration = term_q[dram_cfg_pkg::RD_TERM_LSB +: dram_cfg_pkg::TERM_W];
    assign write_term_duration = term_q[dram_cfg_pkg::WR_TERM_LSB +: dram_cfg_pkg::TERM_W];
    assign ctrl_term_duration = term_q[dram_cfg_pkg::CTRL_TERM_LSB +: dram_cfg_pkg::TERM_W];
    assign ch1_write_to_pchg_gap = pchg_q[dram_cfg_pkg::WP_LSB +: dram_cfg_pkg::WP_W];
    assign ch1_read_to_pchg_gap = pchg_q[dram_cfg_pkg::RP_LSB +: dram_cfg_pkg::RP_W];
    assign ch1_pchg_to_pchg_gap = pchg_q[dram_cfg_pkg::PP_LSB +: dram_cfg_pkg::PP_W];

    assign wr_lo = reg_req.wr && reg_req.be[0];
    assign wr_hi = reg_req.wr && reg_req.be[1];

    assign ch0_rd = cmd.valid && !cmd.channel && (cmd.kind == dram_cfg_pkg::CMD_READ);
    assign ch0_wr = cmd.valid && !cmd.channel && (cmd.kind == dram_cfg_pkg::CMD_WRITE);
    assign ch1_rd = cmd.valid && cmd.channel && (cmd.kind == dram_cfg_pkg::CMD_READ);
    assign ch1_wr = cmd.valid && cmd.channel && (cmd.kind == dram_cfg_pkg::CMD_WRITE);
    assign ch1_pc = cmd.valid && cmd.channel && (cmd.kind == dram_cfg_pkg::CMD_PCHG);

    // Termination control register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            term_q <= dram_cfg_pkg::TERM_RESET;
        else if (reg_req.addr == dram_cfg_pkg::OFF_TERM_LO)
        begin
            if (wr_lo)
                term_q[7:0] <= reg_req.wdata[7:0];
            if (wr_hi)
                term_q[11:8] <= reg_req.wdata[11:8];
        end
    end

    // Boundaries; the lock drops writes silently
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 3; i++)
                bnd_q[i] <= dram_cfg_pkg::BND_RESET;
        end
        else if (!stolen_lock)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (reg_req.addr == 12'(dram_cfg_pkg::OFF_BND1 + 12'(2 * i)))
                begin
                    if (wr_lo)
                        bnd_q[i][7:0] <= reg_req.wdata[7:0];
                    if (wr_hi)
                        bnd_q[i][9:8] <= reg_req.wdata[9:8];
                end
            end
        end
    end

    // Rank attributes, even rank in low byte, odd rank in high byte
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int r = 0; r < dram_cfg_pkg::RANKS; r++)
                attr_q[r] <= dram_cfg_pkg::ATTR_RESET;
        end
        else if (!stolen_lock)
        begin
            if (reg_req.addr == dram_cfg_pkg::OFF_ATTR_LO)
            begin
                if (wr_lo)
                    attr_q[0] <= reg_req.wdata[7:0];
                if (wr_hi)
                    attr_q[1] <= reg_req.wdata[15:8];
            end
            if (reg_req.addr == dram_cfg_pkg::OFF_ATTR_HI)
            begin
                if (wr_lo)
                    attr_q[2] <= reg_req.wdata[7:0];
                if (wr_hi)
                    attr_q[3] <= reg_req.wdata[15:8];
            end
        end
    end

    // Precharge spacing register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pchg_q <= dram_cfg_pkg::PCHG_RESET;
        else if (reg_req.addr == dram_cfg_pkg::OFF_PCHG)
        begin
            if (wr_lo)
                pchg_q[7:0] <= reg_req.wdata[7:0];
            if (wr_hi)
                pchg_q[10:8] <= reg_req.wdata[10:8];
        end
    end

    // Read mux; reserved bits and unmapped offsets read zero
    always_comb
    begin
        rdata_d = 16'h0000;
        case (reg_req.addr)
            dram_cfg_pkg::OFF_TERM_LO: rdata_d = {4'h0, term_q};
            dram_cfg_pkg::OFF_TERM_HI: rdata_d = 16'h0000;
            dram_cfg_pkg::OFF_BND1: rdata_d = {6'h00, bnd_q[0]};
            dram_cfg_pkg::OFF_BND2: rdata_d = {6'h00, bnd_q[1]};
            dram_cfg_pkg::OFF_BND3: rdata_d = {6'h00, bnd_q[2]};
            dram_cfg_pkg::OFF_ATTR_LO: rdata_d = {attr_q[1], attr_q[0]};
            dram_cfg_pkg::OFF_ATTR_HI: rdata_d = {attr_q[3], attr_q[2]};
            dram_cfg_pkg::OFF_PCHG: rdata_d = {5'h00, pchg_q};
            default: rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata_q <= 16'h0000;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rdata_q <= reg_req.rd ? rdata_d : 16'h0000;
            reg_rvalid_q <= reg_req.rd;
        end
    end

    // Channel 0 termination windows
    spacing_timer #(.W(4)) u_rd_odt (
        .clk(clk),
        .rstn(rstn),
        .load(ch0_rd),
        .value(read_term_duration),
        .next_count(rd_odt_nx)
    );

    spacing_timer #(.W(4)) u_wr_odt (
        .clk(clk),
        .rstn(rstn),
        .load(ch0_wr),
        .value(write_term_duration),
        .next_count(wr_odt_nx)
    );

    spacing_timer #(.W(4)) u_ctl_odt (
        .clk(clk),
        .rstn(rstn),
        .load(ch0_rd),
        .value(ctrl_term_duration),
        .next_count(ctl_odt_nx)
    );

    // High from the cycle after the command for exactly the duration
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dram_odt_q <= 1'b0;
            ctrl_odt_q <= 1'b0;
        end
        else
        begin
            dram_odt_q <= (rd_odt_nx != 4'h0) || (wr_odt_nx != 4'h0);
            ctrl_odt_q <= (ctl_odt_nx != 4'h0);
        end
    end

    // Channel 1 precharge trackers, index is rank*8+bank
    for (genvar rb = 0; rb < dram_cfg_pkg::RANKS * dram_cfg_pkg::BANKS; rb++)
    begin : g_rb
        logic [4:0] wp_nx;
        logic [3:0] rp_nx;

        spacing_timer #(.W(5)) u_wp (
            .clk(clk),
            .rstn(rstn),
            .load(ch1_wr && ({cmd.rank, cmd.bank} == 5'(rb))),
            .value(ch1_write_to_pchg_gap),
            .next_count(wp_nx)
        );

        spacing_timer #(.W(4)) u_rp (
            .clk(clk),
            .rstn(rstn),
            .load(ch1_rd && ({cmd.rank, cmd.bank} == 5'(rb))),
            .value(ch1_read_to_pchg_gap),
            .next_count(rp_nx)
        );

        // Count of 1 releases on the following clock, so only >1 blocks
        assign wp_hold[rb] = (wp_nx > 5'h01);
        assign rp_hold[rb] = (rp_nx > 4'h1);
    end

    for (genvar r = 0; r < dram_cfg_pkg::RANKS; r++)
    begin : g_rank
        logic [1:0] pp_nx;

        spacing_timer #(.W(2)) u_pp (
            .clk(clk),
            .rstn(rstn),
            .load(ch1_pc && (cmd.rank == 2'(r))),
            .value(ch1_pchg_to_pchg_gap),
            .next_count(pp_nx)
        );

        assign pp_hold[r] = (pp_nx > 2'h1);
    end

    always_comb
    begin
        for (int i = 0; i < 32; i++)
            block_d[i] = wp_hold[i] || rp_hold[i] || pp_hold[i / 8];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pchg_block_q <= 32'h00000000;
        else
            pchg_block_q <= block_d;
    end
endmodule

// *** tb/dram_cfg_props.sv ***
`timescale 1ns/1ps
module dram_cfg_props (
    input wire logic clk,
    input wire logic rstn,
    input wire dram_cfg_pkg::reg_req_t reg_req,
    input wire logic [15:0] reg_rdata_q,
    input wire logic reg_rvalid_q,
    input wire dram_cfg_pkg::cmd_t cmd,
    input wire logic stolen_lock,
    input wire logic dram_odt_q,
    input wire logic ctrl_odt_q,
    input wire logic [31:0] pchg_block_q
);
    logic [11:0] term_q;
    logic [10:0] gap_q;
    logic [31:0] prev_block_q;
    logic rd0, wr0, any0, wr1, rd1, pc1, any1, term_wr, gap_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    assign rd0 = cmd.valid && cmd.kind == dram_cfg_pkg::CMD_READ && !cmd.channel;
    assign wr0 = cmd.valid && cmd.kind == dram_cfg_pkg::CMD_WRITE && !cmd.channel;
    assign wr1 = cmd.valid && cmd.kind == dram_cfg_pkg::CMD_WRITE && cmd.channel;
    assign rd1 = cmd.valid && cmd.kind == dram_cfg_pkg::CMD_READ && cmd.channel;
    assign pc1 = cmd.valid && cmd.kind == dram_cfg_pkg::CMD_PCHG && cmd.channel;
    assign any0 = rd0 || wr0;
    assign any1 = rd1 || wr1 || pc1;
    assign term_wr = reg_req.wr && reg_req.addr == dram_cfg_pkg::OFF_TERM_LO;
    assign gap_wr = reg_req.wr && reg_req.addr == dram_cfg_pkg::OFF_PCHG;
    // Shadow of the timing fields, so a window is only required when its programmed figure is large enough; its length is not checked
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            term_q <= 12'h000;
            gap_q <= 11'h000;
            prev_block_q <= 32'h0000_0000;
        end
        else
        begin
            prev_block_q <= pchg_block_q;
            if (term_wr && reg_req.be[0]) term_q[7:0] <= reg_req.wdata[7:0];
            if (term_wr && reg_req.be[1]) term_q[11:8] <= reg_req.wdata[11:8];
            if (gap_wr && reg_req.be[0]) gap_q[7:0] <= reg_req.wdata[7:0];
            if (gap_wr && reg_req.be[1]) gap_q[10:8] <= reg_req.wdata[10:8];
        end
    end
    rd_dram_term_a: assert property (rd0 && term_q[11:8] != 4'h0 |-> ##[1:2] dram_odt_q)
        else $error("read termination missing");
    wr_dram_term_a: assert property (wr0 && term_q[7:4] != 4'h0 |-> ##[1:2] dram_odt_q)
        else $error("write termination missing");
    ctrl_term_a: assert property (rd0 && term_q[3:0] != 4'h0 |-> ##[1:2] ctrl_odt_q)
        else $error("controller termination missing");
    ctrl_cause_a: assert property ($rose(ctrl_odt_q) |-> $past(rd0) || $past(rd0, 2))
        else $error("controller termination without read");
    dram_cause_a: assert property ($rose(dram_odt_q) |-> $past(any0) || $past(any0, 2))
        else $error("termination without command");
    wr_block_a: assert property (wr1 && gap_q[10:6] > 5'h02 |-> ##2 |pchg_block_q)
        else $error("write to precharge not blocked");
    rd_block_a: assert property (rd1 && gap_q[5:2] > 4'h2 |-> ##2 |pchg_block_q)
        else $error("read to precharge not blocked");
    pp_block_a: assert property (pc1 && gap_q[1:0] == 2'h3 |-> ##2 |pchg_block_q)
        else $error("precharge spacing not blocked");
    block_cause_a: assert property (|(pchg_block_q & ~prev_block_q) |-> $past(any1) || $past(any1, 2))
        else $error("block without channel 1 command");
    read_answer_a: assert property (reg_req.rd |=> reg_rvalid_q)
        else $error("read not answered");
    rdata_idle_a: assert property (!reg_rvalid_q |-> reg_rdata_q == 16'h0000)
        else $error("read data not zero when idle");
endmodule

// *** tb/dram_term_model.sv ***
`timescale 1ns/1ps
module dram_term_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic odt,
    output int last_run
);
    int run_q;
    // Device side only sees termination as a level; it records how long each window lasted
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_q <= 0;
            last_run <= 0;
        end
        else if (odt)
            run_q <= run_q + 1;
        else if (run_q != 0)
        begin
            last_run <= run_q;
            run_q <= 0;
        end
    end
endmodule

// *** tb/dram_channel_odt_rank_precharge_cfg_tb.sv ***
`timescale 1ns/1ps
module dram_channel_odt_rank_precharge_cfg_tb;
    logic clk, rstn, stolen_lock, reg_rvalid_q, dram_odt_q, ctrl_odt_q;
    dram_cfg_pkg::reg_req_t reg_req;
    dram_cfg_pkg::cmd_t cmd;
    logic [15:0] reg_rdata_q;
    logic [31:0] pchg_block_q;
    int last_run, n, fail_count, num_checks;
    int cyc = 0;
    dram_channel_odt_rank_precharge_cfg dut (.clk(clk), .rstn(rstn), .reg_req(reg_req),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .cmd(cmd),
        .stolen_lock(stolen_lock), .dram_odt_q(dram_odt_q), .ctrl_odt_q(ctrl_odt_q),
        .pchg_block_q(pchg_block_q));
    dram_term_model peer (.clk(clk), .rstn(rstn), .odt(dram_odt_q), .last_run(last_run));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [1:0] b, logic [15:0] d);
        reg_req <= '{1'b1, 1'b0, a, b, d};
        @(posedge clk);
        reg_req.wr <= 1'b0;
        // Idle edge so the next call never re-drives the strobe in this step
        @(posedge clk);
    endtask
    task automatic rd(logic [11:0] a, logic [15:0] e);
        reg_req <= '{1'b0, 1'b1, a, 2'h0, 16'h0000};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {reg_rvalid_q, reg_rdata_q}, {1'b1, e});
        @(posedge clk);
    endtask
    task automatic issue(dram_cfg_pkg::cmd_kind_t k, logic ch, logic [4:0] rb, int sel);
        logic [34:0] v;
        cmd <= '{1'b1, k, ch, rb[4:3], rb[2:0]};
        @(posedge clk);
        cmd.valid <= 1'b0;
        n = 0;
        repeat (12)
        begin
            #1;
            v = {dram_odt_q, &pchg_block_q[31:24], ctrl_odt_q, pchg_block_q};
            if (v[sel] === 1'b1) n++;
            @(posedge clk);
        end
    endtask
    task automatic t_regs;
        logic [11:0] offs [9] = '{12'h29C, 12'h29E, 12'h602, 12'h604, 12'h606, 12'h608,
            12'h60A, 12'h650, 12'h700};
        foreach (offs[i]) rd(offs[i], 16'h0000);
        wr(dram_cfg_pkg::OFF_BND1, 2'h3, 16'hFFFF);
        rd(dram_cfg_pkg::OFF_BND1, 16'h03FF);
        wr(dram_cfg_pkg::OFF_BND3, 2'h3, 16'h0123); // Cumulative topmost boundary
        wr(dram_cfg_pkg::OFF_ATTR_LO, 2'h1, 16'hA55A);
        rd(dram_cfg_pkg::OFF_ATTR_LO, 16'h005A);
        wr(dram_cfg_pkg::OFF_ATTR_HI, 2'h2, 16'h3CC3);
        wr(dram_cfg_pkg::OFF_TERM_HI, 2'h3, 16'hFFFF);
        rd(dram_cfg_pkg::OFF_TERM_HI, 16'h0000);
        stolen_lock <= 1'b1;
        foreach (offs[i]) if (i > 1 && i < 7) wr(offs[i], 2'h3, 16'h0155);
        rd(dram_cfg_pkg::OFF_BND1, 16'h03FF);
        rd(dram_cfg_pkg::OFF_BND2, 16'h0000);
        rd(dram_cfg_pkg::OFF_BND3, 16'h0123);
        rd(dram_cfg_pkg::OFF_ATTR_HI, 16'h3C00);
        stolen_lock <= 1'b0;
        wr(dram_cfg_pkg::OFF_BND2, 2'h3, 16'h0200);
        rd(dram_cfg_pkg::OFF_BND2, 16'h0200);
    endtask
    task automatic t_odt;
        wr(dram_cfg_pkg::OFF_TERM_LO, 2'h3, 16'h0352); // Synchronous values
        issue(dram_cfg_pkg::CMD_READ, 1'b0, 5'h00, 32);
        chk("ctrl term", n, 2);
        chk("read term", last_run, 3);
        issue(dram_cfg_pkg::CMD_WRITE, 1'b0, 5'h00, 32);
        chk("ctrl on write", n, 0);
        chk("write term", last_run, 5);
        issue(dram_cfg_pkg::CMD_READ, 1'b1, 5'h00, 34);
        chk("ch1 term", n, 0);
        wr(dram_cfg_pkg::OFF_TERM_LO, 2'h2, 16'h0050); // Clears read duration only
        issue(dram_cfg_pkg::CMD_READ, 1'b0, 5'h00, 34);
        chk("zero term", n, 0);
    endtask
    task automatic t_pchg;
        wr(dram_cfg_pkg::OFF_PCHG, 2'h3, 16'hFFFF);
        rd(dram_cfg_pkg::OFF_PCHG, 16'h07FF);
        wr(dram_cfg_pkg::OFF_PCHG, 2'h3, 16'h010F);
        issue(dram_cfg_pkg::CMD_WRITE, 1'b1, 5'h0A, 10);
        chk("wr gap", n, 3);
        issue(dram_cfg_pkg::CMD_READ, 1'b1, 5'h10, 16);
        chk("rd gap", n, 2);
        issue(dram_cfg_pkg::CMD_PCHG, 1'b1, 5'h18, 33);
        chk("pchg gap", n, 2);
        issue(dram_cfg_pkg::CMD_WRITE, 1'b0, 5'h0A, 10);
        chk("ch0 gap", n, 0);
    endtask
    task final_report;
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, well above the under two hundred cycles the scenarios need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            final_report;
        end
    end
    initial
    begin
        rstn = 1'b0;
        reg_req = '0;
        cmd = '0;
        stolen_lock = 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs;
        t_odt;
        t_pchg;
        final_report;
    end
endmodule
bind dram_channel_odt_rank_precharge_cfg dram_cfg_props props (.clk(clk), .rstn(rstn),
    .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .cmd(cmd),
    .stolen_lock(stolen_lock), .dram_odt_q(dram_odt_q), .ctrl_odt_q(ctrl_odt_q),
    .pchg_block_q(pchg_block_q));
